// ==== shared/irs_pkg.sv ====
// constants and types for the two-wire register slave
// assumes one system clock of 20 MHz; bus pins pass through synchronisers
package irs_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BUS_MAX_HZ    = 400_000;    // fast-mode ceiling
  localparam int unsigned BUS_MIN_CYC   = CLK_HZ / BUS_MAX_HZ;
  localparam int unsigned STRETCH_NS    = 500;        // clock hold after each byte the slave acks
  localparam int unsigned STRETCH_CYC   = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0]  STRETCH_LOAD  = 5'(STRETCH_CYC);

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [5:0]  DEV_ADDR_HI   = 6'h35;      // 110101b
  localparam int unsigned PTR_INC_BIT   = 7;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // register storage and control bits
  // ----------------------------------------------------------------
  localparam int unsigned REG_DEPTH     = 128;
  localparam logic [6:0]  OFF_BUS_CTRL  = 7'h39;      // interface disable register
  localparam int unsigned BUS_OFF_BIT   = 3;
  localparam logic [6:0]  OFF_PORT_CFG  = 7'h3a;      // serial port wiring register
  localparam int unsigned WIRE3_BIT     = 0;
  localparam logic [7:0]  REG_RST_VAL   = 8'h00;

  // ----------------------------------------------------------------
  // transfer state, gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IRS_IDLE  = 4'h0,
    IRS_ADDR  = 4'h1,
    IRS_AACK  = 4'h3,
    IRS_PTR   = 4'h2,
    IRS_PACK  = 4'h6,
    IRS_WDAT  = 4'h7,
    IRS_WACK  = 4'h5,
    IRS_RDAT  = 4'h4,
    IRS_RACK  = 4'hc
  } irs_state_t;

endpackage : irs_pkg

// ==== core/irs_sync2.sv ====
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs come from pins outside the clk domain
`timescale 1ns/1ns
module irs_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff  <= '1;
      sync_out <= '1;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : irs_sync2

// ==== core/irs_regfile.sv ====
// register storage reached through the two-wire slave
// assumes one write per cycle at most; read is combinational by index
`timescale 1ns/1ns
module irs_regfile (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // write port
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // read port
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data,
  // control bits held in storage
  output logic            bus_off,
  output logic            wire3_mode
);
  import irs_pkg::*;

  logic [7:0] mem_ff [REG_DEPTH];

  // read by index
  assign rd_data    = mem_ff[rd_addr];
  assign bus_off    = mem_ff[OFF_BUS_CTRL][BUS_OFF_BIT];
  assign wire3_mode = mem_ff[OFF_PORT_CFG][WIRE3_BIT];

  // byte storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_ff[i] <= REG_RST_VAL;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

endmodule : irs_regfile

// ==== core/irs_slave.sv ====
// two-wire register slave: framing, addressing, pointer, read and write
// assumes bus pins are open drain with pull-ups outside; clk is 20 MHz
`timescale 1ns/1ns
module irs_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // bus clock pin, split
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // bus data pin, split
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // straps
  input  wire logic        iface_sel,
  input  wire logic        address_lsb_select_pin,
  // status and mode outputs
  output logic             alt_port_en,
  output logic             alt_port_wire3,
  output logic             bus_disabled,
  output logic             bus_busy,
  output logic             addressed,
  // register write notification
  output logic             reg_wr_stb,
  output logic [6:0]       reg_wr_addr,
  output logic [7:0]       reg_wr_data
);
  import irs_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       sel_s;
  logic       address_low_bit_input;

  // fast-mode bus gives BUS_MIN_CYC samples per bit, ample for edges
  irs_sync2 #(.W(4)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({scl_i, sda_i, iface_sel, address_lsb_select_pin}),
    .sync_out (pins_s)
  );

  assign scl_s                 = pins_s[3];
  assign sda_s                 = pins_s[2];
  assign sel_s                 = pins_s[1];
  assign address_low_bit_input = pins_s[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  irs_state_t  state_ff,   nxt_state;
  logic        scl_d_ff;
  logic        sda_d_ff;
  logic [2:0]  bit_ff,     nxt_bit;
  logic [7:0]  shift_ff,   nxt_shift;
  logic [6:0]  ptr_ff,     nxt_ptr;
  logic        inc_ff,     nxt_inc;
  logic        drive_ff,   nxt_drive;
  logic [4:0]  hold_ff,    nxt_hold;
  logic        busy_ff,    nxt_busy;
  logic        seen_ff,    nxt_seen;
  logic        rd_ff,      nxt_rd;
  logic        wr_ff;
  logic [6:0]  wr_addr_ff;
  logic [7:0]  wr_data_ff;

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       i2c_mode;
  logic [6:0] own_addr;
  logic       addr_hit;
  logic       off_bit;
  logic       wire3_bit;
  logic [7:0] rd_byte;
  logic [6:0] ptr_step;
  logic       wr_now;
  logic [7:0] rx_byte;
  logic       byte_end;

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_ev  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign i2c_mode = sel_s;
  assign own_addr = {DEV_ADDR_HI, address_low_bit_input};
  assign rx_byte  = shift_ff;
  // only the top seven bits pick the device; bit 0 is direction
  assign addr_hit = (rx_byte[7:1] == own_addr) & ~off_bit;
  // autoincrement moves on, otherwise the pointer holds
  assign ptr_step = inc_ff ? ptr_ff + 7'h01 : ptr_ff;
  // a byte ends on the fall after eight rises; seen_ff masks the start fall
  assign byte_end = scl_fall & (bit_ff == 3'h0) & seen_ff;
  assign wr_now   = (state_ff == IRS_WDAT) & byte_end;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  irs_regfile u_regs (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr_en      (wr_now),
    .wr_addr    (ptr_ff),
    .wr_data    (rx_byte),
    .rd_addr    (ptr_ff),
    .rd_data    (rd_byte),
    .bus_off    (off_bit),
    .wire3_mode (wire3_bit)
  );

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  // receive states count bits on clock rise; the count wraps to 0 after
  // eight, so a fall with bit_ff==0 ends a byte. read data shifts on fall.
  always_comb begin
    nxt_state = state_ff;
    nxt_bit   = bit_ff;
    nxt_shift = shift_ff;
    nxt_ptr   = ptr_ff;
    nxt_inc   = inc_ff;
    nxt_drive = drive_ff;
    nxt_hold  = (hold_ff != 5'h00) ? hold_ff - 5'h01 : 5'h00;
    nxt_busy  = busy_ff;
    nxt_seen  = seen_ff;
    nxt_rd    = rd_ff;
    if (!i2c_mode) begin
      // alternate port owns the pins; stay silent
      nxt_state = IRS_IDLE;
      nxt_drive = 1'b0;
      nxt_hold  = 5'h00;
      nxt_busy  = 1'b0;
    end else if (start_ev) begin
      // start or repeated start always restarts address phase
      nxt_state = IRS_ADDR;
      nxt_bit   = 3'h0;
      nxt_seen  = 1'b0;
      nxt_drive = 1'b0;
      nxt_busy  = 1'b1;
    end else if (stop_ev) begin
      nxt_state = IRS_IDLE;
      nxt_drive = 1'b0;
      nxt_busy  = 1'b0;
    end else begin
      case (state_ff)
        IRS_ADDR, IRS_PTR, IRS_WDAT: begin
          if (scl_rise) begin
            // msb arrives first
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit   = bit_ff + 3'h1;
            nxt_seen  = 1'b1;
          end else if (byte_end && state_ff == IRS_ADDR) begin
            if (addr_hit) begin
              nxt_state = IRS_AACK;
              nxt_drive = 1'b1;
              nxt_hold  = STRETCH_LOAD;
              nxt_rd    = rx_byte[0];                          // direction kept
            end else begin
              nxt_state = IRS_IDLE;
            end
          end else if (byte_end && state_ff == IRS_PTR) begin
            nxt_ptr   = rx_byte[6:0];
            nxt_inc   = rx_byte[PTR_INC_BIT];
            nxt_state = IRS_PACK;
            nxt_drive = 1'b1;
            nxt_hold  = STRETCH_LOAD;
          end else if (byte_end) begin
            // byte stored this cycle, then pointer steps if autoincrement is set
            nxt_ptr   = ptr_step;
            nxt_state = IRS_WACK;
            nxt_drive = 1'b1;
            nxt_hold  = STRETCH_LOAD;
          end
        end
        IRS_AACK: begin
          nxt_seen = 1'b0;
          if (scl_fall) begin
            nxt_bit = 3'h0;
            if (rd_ff) begin
              // read header: first byte out at once, autoincrement kept
              nxt_state = IRS_RDAT;
              nxt_shift = rd_byte;
              nxt_drive = ~rd_byte[7];
            end else begin
              nxt_state = IRS_PTR;
              nxt_drive = 1'b0;
            end
          end
        end
        IRS_PACK, IRS_WACK: begin
          nxt_seen = 1'b0;
          if (scl_fall) begin
            nxt_state = IRS_WDAT;
            nxt_bit   = 3'h0;
            nxt_drive = 1'b0;
          end
        end
        IRS_RDAT: begin
          if (scl_fall && bit_ff == BIT_LAST) begin
            // release for controller_ack, advance pointer if autoincrement is set
            nxt_state = IRS_RACK;
            nxt_drive = 1'b0;
            nxt_ptr   = ptr_step;
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_bit   = bit_ff + 3'h1;
            nxt_drive = ~shift_ff[6];
          end
        end
        IRS_RACK: begin
          if (scl_rise) begin
            // controller_final_nack ends the read; wait for stop
            nxt_bit = {2'b00, sda_s};
          end else if (scl_fall && bit_ff[0]) begin
            nxt_state = IRS_IDLE;
          end else if (scl_fall) begin
            nxt_state = IRS_RDAT;
            nxt_bit   = 3'h0;
            nxt_shift = rd_byte;
            nxt_drive = ~rd_byte[7];
          end
        end
        default: begin
          nxt_state = IRS_IDLE;
          nxt_drive = 1'b0;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IRS_IDLE;
      bit_ff   <= 3'h0;
      shift_ff <= 8'h00;
      ptr_ff   <= 7'h00;
      inc_ff   <= 1'b0;
      drive_ff <= 1'b0;
      hold_ff  <= 5'h00;
      busy_ff  <= 1'b0;
      seen_ff  <= 1'b0;
      rd_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_ff   <= nxt_bit;
      shift_ff <= nxt_shift;
      ptr_ff   <= nxt_ptr;
      inc_ff   <= nxt_inc;
      drive_ff <= nxt_drive;
      hold_ff  <= nxt_hold;
      busy_ff  <= nxt_busy;
      seen_ff  <= nxt_seen;
      rd_ff    <= nxt_rd;
    end
  end

  // edge history on synchronised pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // pins only ever pull low; level outputs fixed at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_o  <= 1'b0;
      scl_o  <= 1'b0;
      sda_oe <= nxt_drive;
      scl_oe <= (nxt_hold != 5'h00);
    end
  end

  // mode and status outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alt_port_en    <= 1'b0;
      alt_port_wire3 <= 1'b0;
      bus_disabled   <= 1'b0;
      bus_busy       <= 1'b0;
      addressed      <= 1'b0;
    end else begin
      alt_port_en    <= ~sel_s;
      alt_port_wire3 <= wire3_bit;
      bus_disabled   <= off_bit;
      bus_busy       <= nxt_busy;
      addressed      <= (nxt_state != IRS_IDLE) && (nxt_state != IRS_ADDR);
    end
  end

  // register write notification
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff      <= 1'b0;
      wr_addr_ff <= 7'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_ff      <= wr_now;
      wr_addr_ff <= wr_now ? ptr_ff : wr_addr_ff;
      wr_data_ff <= wr_now ? rx_byte : wr_data_ff;
    end
  end

  assign reg_wr_stb  = wr_ff;
  assign reg_wr_addr = wr_addr_ff;
  assign reg_wr_data = wr_data_ff;

endmodule : irs_slave

// ==== bench/irs_slave_monitor.sv ====
// checker for the two-wire register slave, bound to its ports
// assumes one clk domain with rst_b as asynchronous active-low reset
`timescale 1ns/1ns
module irs_slave_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // straps and status
  input wire logic iface_sel,
  input wire logic alt_port_en,
  input wire logic bus_disabled,
  input wire logic bus_busy,
  input wire logic addressed,
  input wire logic reg_wr_stb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----
  // properties
  // ----
  property p_open_drain; !scl_o && !sda_o; endproperty
  property p_stretch_len; $rose(scl_oe) |-> scl_oe [*8] ##[1:4] !scl_oe; endproperty
  property p_stretch_ack; $rose(scl_oe) |-> sda_oe; endproperty
  property p_alt_quiet; alt_port_en |-> !sda_oe && !scl_oe && !bus_busy; endproperty
  property p_alt_follow; $changed(iface_sel) |-> ##[1:4] (alt_port_en != iface_sel); endproperty
  property p_busy_start; $rose(bus_busy) |-> scl_i && !sda_i; endproperty
  property p_busy_stop; $fell(bus_busy) |-> scl_i && sda_i; endproperty
  property p_wr_pulse; reg_wr_stb |=> !reg_wr_stb; endproperty
  property p_wr_addr; reg_wr_stb |-> addressed && bus_busy; endproperty
  property p_sda_low_clk; $changed(sda_oe) |-> !scl_i; endproperty
  property p_addr_busy; addressed |-> bus_busy; endproperty
  property p_disabled; bus_disabled && !addressed |=> !addressed; endproperty

  a_open_drain:
    assert property (p_open_drain) else $error("bus line driven high");
  a_stretch_len:
    assert property (p_stretch_len) else $error("clock hold length wrong");
  a_stretch_ack:
    assert property (p_stretch_ack) else $error("clock hold without ack");
  a_alt_quiet:
    assert property (p_alt_quiet) else $error("bus active in alternate mode");
  a_alt_follow:
    assert property (p_alt_follow) else $error("mode output not following select");
  a_busy_start:
    assert property (p_busy_start) else $error("busy without start");
  a_busy_stop:
    assert property (p_busy_stop) else $error("idle without stop");
  a_wr_pulse:
    assert property (p_wr_pulse) else $error("write strobe too long");
  a_wr_addr:
    assert property (p_wr_addr) else $error("write while not addressed");
  a_sda_low_clk:
    assert property (p_sda_low_clk) else $error("data changed with clock high");
  a_addr_busy:
    assert property (p_addr_busy) else $error("addressed on idle bus");
  a_disabled:
    assert property (p_disabled) else $error("addressed while disabled");

  // main scenarios seen
  c_stretch: cover property ($rose(scl_oe));
  c_write: cover property (reg_wr_stb);
  c_alt: cover property (alt_port_en);
endmodule : irs_slave_monitor

// ==== bench/irs_bus_master.sv ====
// behavioural two-wire bus controller driving open-drain pulls
// assumes lines resolved with pull-ups outside; 400 ns bit period
`timescale 1ns/1ns
module irs_bus_master (
  // resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // pulls, high drags the line low
  output logic      scl_low,
  output logic      sda_low
);
  int timeouts = 0;
  initial begin
    scl_low = 0;
    sda_low = 0;
  end

  // wait for clock release, bounded
  task automatic wait_hi;
    int n;
    for (n = 0; n < 300 && scl !== 1'b1; n++) #10;
    if (n == 300) timeouts++;
  endtask : wait_hi

  // one bit: data set while clock low, sampled at end of high
  task automatic bit_cyc(input logic lo, output logic smp);
    #50 sda_low = lo;
    #200 scl_low = 0;
    wait_hi();
    #150 smp = sda;
    scl_low = 1;
  endtask : bit_cyc

  // start or repeated start
  task automatic go_start;
    #50 sda_low = 0;
    #200 scl_low = 0;
    wait_hi();
    #200 sda_low = 1;
    #200 scl_low = 1;
  endtask : go_start

  task automatic go_stop;
    #50 sda_low = 1;
    #200 scl_low = 0;
    wait_hi();
    #200 sda_low = 0;
    #400;
  endtask : go_stop

  // byte out msb first, line released for ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(!b[i], s);
    bit_cyc(1'b0, s);
    ack = !s;
  endtask : put_byte

  // byte in, then ack or final nack
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, s);
      d[i] = s;
    end
    bit_cyc(!last, s);
  endtask : get_byte
endmodule : irs_bus_master

// ==== bench/irs_slave_tb.sv ====
// self-checking bench for the two-wire register slave
// assumes irs_pkg compiled first; master model drives the bus
`timescale 1ns/1ns
module irs_slave_tb;
  import irs_pkg::*;
  logic clk = 0, rst_b = 0, iface_sel = 1, lsb_pin = 0;
  logic scl_o, scl_oe, sda_o, sda_oe, alt_port_en, alt_port_wire3;
  logic bus_disabled, bus_busy, addressed, reg_wr_stb;
  logic [6:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  wire m_scl, m_sda;
  wire scl_ln = !(scl_oe || m_scl);
  wire sda_ln = !(sda_oe || m_sda);
  int miscompares = 0, cmp_count = 0;
  logic [14:0] wq[$];

  always #25 clk = ~clk;

  irs_slave u_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl_ln), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe(sda_oe),
    .iface_sel(iface_sel), .address_lsb_select_pin(lsb_pin),
    .alt_port_en(alt_port_en), .alt_port_wire3(alt_port_wire3),
    .bus_disabled(bus_disabled), .bus_busy(bus_busy), .addressed(addressed),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  irs_bus_master u_m (.scl(scl_ln), .sda(sda_ln), .scl_low(m_scl), .sda_low(m_sda));

  // log every register write
  always @(posedge clk) if (reg_wr_stb) wq.push_back({reg_wr_addr, reg_wr_data});

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] b, input logic ack_exp);
    logic a;
    u_m.put_byte(b, a);
    chk({14'h0, a}, {14'h0, ack_exp});
  endtask : send

  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_m.get_byte(last, d);
    chk({7'h0, d}, {7'h0, exp});
  endtask : recv

  task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
    logic [14:0] got;
    got = wq.size() ? wq.pop_front() : 15'h7fff;
    chk(got, {a, d});
  endtask : chk_wr

  task automatic end_sim;
    miscompares += u_m.timeouts;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    #2_000_000;
    miscompares++;
    end_sim();
  end

  // main sequence; the master starts 2 ns after an edge, off every clk edge
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk({9'h0, alt_port_en, alt_port_wire3, bus_disabled, bus_busy, addressed, reg_wr_stb}, '0);
    u_m.go_start();
    chk({14'h0, bus_busy}, 15'h1);
    send(8'hd4, 1'b1);
    send(8'h10, 1'b1);
    send(8'hc1, 1'b1);
    send(8'h1e, 1'b1);
    u_m.go_stop();
    chk({14'h0, bus_busy}, 15'h0);
    chk_wr(7'h10, 8'hc1);
    chk_wr(7'h10, 8'h1e);
    u_m.go_start();
    send(8'hd4, 1'b1);
    send(8'hff, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    u_m.go_stop();
    chk_wr(7'h7f, 8'h11);
    chk_wr(7'h00, 8'h22);
    u_m.go_start();
    send(8'hd4, 1'b1);
    send(8'h3a, 1'b1);
    send(8'h01, 1'b1);
    u_m.go_stop();
    chk_wr(7'h3a, 8'h01);
    chk({14'h0, alt_port_wire3}, 15'h1);
    u_m.go_start();
    send(8'hd4, 1'b1);
    send(8'h10, 1'b1);
    u_m.go_start();
    send(8'hd5, 1'b1);
    recv(1'b1, 8'h1e);
    u_m.go_stop();
    u_m.go_start();
    send(8'hd4, 1'b1);
    send(8'hff, 1'b1);
    u_m.go_start();
    send(8'hd5, 1'b1);
    recv(1'b0, 8'h11);
    recv(1'b1, 8'h22);
    u_m.go_stop();
    u_m.go_start();
    send(8'hd6, 1'b0);
    u_m.go_stop();
    @(posedge clk) lsb_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #2;
    u_m.go_start();
    send(8'hd6, 1'b1);
    send(8'h3a, 1'b1);
    u_m.go_stop();
    @(posedge clk) iface_sel <= 1'b0;
    repeat (5) @(posedge clk);
    #2;
    chk({14'h0, alt_port_en}, 15'h1);
    u_m.go_start();
    send(8'hd6, 1'b0);
    u_m.go_stop();
    @(posedge clk) iface_sel <= 1'b1;
    repeat (5) @(posedge clk);
    #2;
    chk({14'h0, alt_port_en}, 15'h0);
    u_m.go_start();
    send(8'hd6, 1'b1);
    send(8'h39, 1'b1);
    send(8'h08, 1'b1);
    u_m.go_stop();
    chk_wr(7'h39, 8'h08);
    chk({14'h0, bus_disabled}, 15'h1);
    u_m.go_start();
    send(8'hd6, 1'b0);
    u_m.go_stop();
    @(posedge clk) rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk({14'h0, bus_disabled}, 15'h0);
    u_m.go_start();
    send(8'hd6, 1'b1);
    u_m.go_stop();
    end_sim();
  end
endmodule : irs_slave_tb

bind irs_slave irs_slave_monitor u_mon (.clk, .rst_b, .scl_i, .scl_o, .scl_oe, .sda_i,
  .sda_o, .sda_oe, .iface_sel, .alt_port_en, .bus_disabled, .bus_busy, .addressed,
  .reg_wr_stb);
